// *** smi_group_pkg.sv ***
// Package for the management interrupt group and either-edge block.
// Assumes an 8-bit register port in the power-management I/O space.
package smi_group_pkg;

  // Register offsets within the power-management block
  localparam logic [7:0] OFS_SMI_STATUS_B = 8'h13;
  localparam logic [7:0] OFS_SMI_ENABLE_A = 8'h14;
  localparam logic [7:0] OFS_SMI_ENABLE_B = 8'h15;
  localparam logic [7:0] OFS_MISC_STATUS = 8'h16;

  // Reset values
  localparam logic [7:0] RST_SMI_ENABLE = 8'h00;
  localparam logic [7:0] RST_MISC_STATUS = 8'h00;
  localparam logic [7:0] RST_SMI_STATUS = 8'h00;

  // Status register b field positions
  localparam int STB_MOUSE = 0;
  localparam int STB_KBD = 1;
  localparam int STB_IR = 2;
  localparam int STB_GEN = 3;
  localparam int STB_KBC = 4;
  localparam int STB_SLEEP = 7;

  // Enable register b field positions
  localparam int ENB_KBC = 4;
  localparam int ENB_CIR = 5;
  localparam int ENB_PME = 6;
  localparam int ENB_SMI = 7;

  // Misc status field positions
  localparam int MSC_STANDBY = 4;
  localparam int MSC_EDGE_BITS = 4;

  // Register access strobe group
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Interrupt sources from neighbouring functions
  typedef struct packed {
    logic ring_pme_status;
    logic parallel;
    logic serial_b;
    logic serial_a;
    logic floppy;
    logic gpio_group_b_irq;
    logic gpio_group_a_irq;
    logic watchdog;
    logic mouse;
    logic keyboard;
    logic general_event;
    logic kbc_port_pin;
    logic cir_pme_status;
    logic sleep_request_bit;
  } smi_src_t;

endpackage

// *** smi_group_and_edge_irq.sv ***
// Management interrupt group, routing and either-edge GPIO status.
// Assumes a synchronous 8-bit register port; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module smi_group_and_edge_irq
#(
  parameter int EDGE_PINS = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire smi_group_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Interrupt sources, same clock
  input wire smi_group_pkg::smi_src_t src,
  // Asynchronous pins
  input wire logic serial_b_receive,
  input wire logic infrared_receive_alt,
  input wire logic [EDGE_PINS-1:0] edge_pins,
  input wire logic standby_supply_reset,
  // Configuration from other logical devices
  input wire logic ir_mux_select,
  input wire logic smi_to_serial_frame,
  input wire logic [EDGE_PINS-1:0] edge_mode_select,
  input wire logic [EDGE_PINS-1:0] edge_polarity,
  input wire logic [EDGE_PINS-1:0] edge_group_enable,
  input wire logic system_power_on_n,
  // Outputs
  output logic group_mgmt_irq_n_o,
  output logic group_mgmt_irq_n_oe,
  output logic serial_frame_irq2,
  output logic smi_to_power_event,
  output logic [EDGE_PINS-1:0] either_edge_irq,
  output logic [EDGE_PINS-1:0] edge_gpio_data,
  output logic acpi_control_irq
);

  // Logic serves exactly four named edge pins; the misc status
  // register holds four edge bits below the standby flag, so any
  // other count would move the standby bit or drop pins
  if (EDGE_PINS != smi_group_pkg::MSC_EDGE_BITS)
  begin : g_pin_count
    $error("EDGE_PINS must be 4");
  end

  // Registers
  logic [7:0] smi_enable_a_q;
  logic [7:0] smi_enable_b_q;
  logic [EDGE_PINS-1:0] edge_status_q;
  logic standby_supply_reset_status_q;
  logic infrared_activity_status_q;
  logic general_event_status_q;
  logic sleep_request_smi_status_q;
  // Synchronisers: stage 1, stage 2, previous
  logic [EDGE_PINS+2:0] sync1_q;
  logic [EDGE_PINS+2:0] sync2_q;
  logic [EDGE_PINS+2:0] prev_q;
  logic sleep_prev_q;
  logic standby_seen_q;
  logic sci_q;
  logic smi_group_q;
  logic [EDGE_PINS-1:0] edge_gpio_data_q; // Pin data seen by software

  // Decoded strobes
  logic rd_status_b;
  logic wr_misc;
  logic ir_sel;
  logic ir_sel_prev; // Selected IR input, one sample older
  logic ir_edge;
  logic [EDGE_PINS-1:0] edge_hit;
  logic standby_rise;
  logic [7:0] status_b;
  logic smi_any;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign rd_status_b = req.rd & hit(req.addr, smi_group_pkg::OFS_SMI_STATUS_B);
  assign wr_misc = req.wr & hit(req.addr, smi_group_pkg::OFS_MISC_STATUS);

  // Pin synchronisers, two flops before use
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= {standby_supply_reset, infrared_receive_alt,
                  serial_b_receive, edge_pins};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // IR source chosen after the mux, from synced copies
  assign ir_sel = ir_mux_select ? sync2_q[EDGE_PINS+1] :
    sync2_q[EDGE_PINS];
  // Same mux on the older copy: flipping the mux alone is no edge,
  // since each input is compared only with its own history
  assign ir_sel_prev = ir_mux_select ? prev_q[EDGE_PINS+1] :
    prev_q[EDGE_PINS];
  // Edge is a change between successive samples
  assign ir_edge = ir_sel ^ ir_sel_prev;
  assign edge_hit = sync2_q[EDGE_PINS-1:0] ^ prev_q[EDGE_PINS-1:0];
  assign standby_rise = sync2_q[EDGE_PINS+2] & ~prev_q[EDGE_PINS+2];

  // Enable registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      smi_enable_a_q <= smi_group_pkg::RST_SMI_ENABLE;
      smi_enable_b_q <= smi_group_pkg::RST_SMI_ENABLE;
    end
    else if (req.wr)
    begin
      // Reserved bits none here; all eight are writable
      if (hit(req.addr, smi_group_pkg::OFS_SMI_ENABLE_A))
        smi_enable_a_q <= req.wdata;
      if (hit(req.addr, smi_group_pkg::OFS_SMI_ENABLE_B))
        smi_enable_b_q <= req.wdata;
    end
  end

  // Edge status: set wins over write-one clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      edge_status_q <= smi_group_pkg::RST_MISC_STATUS[EDGE_PINS-1:0];
    else
      // Recorded whatever the mode or enable
      edge_status_q <= edge_hit | (edge_status_q &
        ~(wr_misc ? req.wdata[EDGE_PINS-1:0] : '0));
  end

  // Standby-supply power-on flag
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      standby_supply_reset_status_q <= 1'b0;
    else if (standby_rise)
      standby_supply_reset_status_q <= 1'b1;
    else if (wr_misc && req.wdata[smi_group_pkg::MSC_STANDBY])
      standby_supply_reset_status_q <= 1'b0;
  end

  // ACPI_CONTROL_IRQ when power comes on after a standby reset
  // Limitation: power already on when the flag rises still gives
  // one ACPI_CONTROL_IRQ, since the level, not its edge, ends the wait
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      standby_seen_q <= 1'b0;
      sci_q <= 1'b0;
    end
    else
    begin
      if (standby_rise)
        standby_seen_q <= 1'b1;
      else if (!system_power_on_n)
        standby_seen_q <= 1'b0;
      // One-cycle ACPI_CONTROL_IRQ at the first power-on after the reset
      sci_q <= standby_seen_q & ~system_power_on_n;
    end
  end

  // Read-to-clear flags; a coinciding event keeps the bit
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      infrared_activity_status_q <= 1'b0;
      general_event_status_q <= 1'b0;
      sleep_request_smi_status_q <= 1'b0;
      sleep_prev_q <= 1'b0;
    end
    else
    begin
      sleep_prev_q <= src.sleep_request_bit;
      if (ir_edge)
        infrared_activity_status_q <= 1'b1;
      else if (rd_status_b)
        infrared_activity_status_q <= 1'b0;
      if (src.general_event)
        general_event_status_q <= 1'b1;
      else if (rd_status_b)
        general_event_status_q <= 1'b0;
      // Setting the sleep bit is the SMI cause
      if (src.sleep_request_bit && !sleep_prev_q)
        sleep_request_smi_status_q <= 1'b1;
      else if (rd_status_b)
        sleep_request_smi_status_q <= 1'b0;
    end
  end

  // Status register b view; reserved 5,6 read zero
  always_comb
  begin
    status_b = smi_group_pkg::RST_SMI_STATUS;
    status_b[smi_group_pkg::STB_MOUSE] = src.mouse;
    status_b[smi_group_pkg::STB_KBD] = src.keyboard;
    status_b[smi_group_pkg::STB_IR] = infrared_activity_status_q;
    status_b[smi_group_pkg::STB_GEN] = general_event_status_q;
    status_b[smi_group_pkg::STB_KBC] = src.kbc_port_pin;
    status_b[smi_group_pkg::STB_SLEEP] = sleep_request_smi_status_q;
  end

  // Group combine; ring and CIR use power-event status
  always_comb
  begin
    smi_any = |(smi_enable_a_q & {src.watchdog, src.gpio_group_a_irq,
      src.gpio_group_b_irq, src.floppy, src.serial_a, src.serial_b,
      src.parallel, src.ring_pme_status});
    smi_any = smi_any | (|(smi_enable_b_q[3:0] &
      status_b[3:0]));
    smi_any = smi_any | (smi_enable_b_q[smi_group_pkg::ENB_KBC] &
      src.kbc_port_pin);
    smi_any = smi_any | (smi_enable_b_q[smi_group_pkg::ENB_CIR] &
      src.cir_pme_status);
    // Sleep-triggered SMI always joins the group
    smi_any = smi_any | sleep_request_smi_status_q;
  end

  // Registered group level avoids glitches on the pin
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      smi_group_q <= 1'b0;
    else
      smi_group_q <= smi_any;
  end

  // Read data register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (req.rd)
    begin
      case (req.addr)
        smi_group_pkg::OFS_SMI_STATUS_B: rdata <= status_b;
        smi_group_pkg::OFS_SMI_ENABLE_A: rdata <= smi_enable_a_q;
        smi_group_pkg::OFS_SMI_ENABLE_B: rdata <= smi_enable_b_q;
        smi_group_pkg::OFS_MISC_STATUS:
          rdata <= {3'h0, standby_supply_reset_status_q,
                    edge_status_q};
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Pin routing: float unless enabled; mux picks destination
  assign group_mgmt_irq_n_oe = smi_enable_b_q[smi_group_pkg::ENB_SMI] &
    ~smi_to_serial_frame;
  assign group_mgmt_irq_n_o = ~smi_group_q;
  assign serial_frame_irq2 = smi_enable_b_q[smi_group_pkg::ENB_SMI] &
    smi_to_serial_frame & smi_group_q;
  assign smi_to_power_event = smi_enable_b_q[smi_group_pkg::ENB_PME] &
    smi_group_q;

  // Either-edge interrupt only with mode and group enable
  assign either_edge_irq = edge_status_q & edge_mode_select &
    edge_group_enable;
  // Pin data sees polarity even in either-edge mode; registered so
  // the data bit cannot glitch while polarity is rewritten.
  // Costs one more cycle of lag, which polling software never sees.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      edge_gpio_data_q <= '0;
    else
      edge_gpio_data_q <= sync2_q[EDGE_PINS-1:0] ^ edge_polarity;
  end
  assign edge_gpio_data = edge_gpio_data_q;
  assign acpi_control_irq = sci_q;

endmodule
`default_nettype wire

// *** smi_group_asserts.sv ***
// Port checker for the management interrupt group block.
// Assumes enable writes land on the edge that takes the strobe.
`timescale 1ns/1ps
`default_nettype none
module smi_group_asserts
#(
  parameter int EDGE_PINS = 4
)
(
  // Clock, reset and register port
  input wire logic clock,
  input wire logic rstn,
  input wire smi_group_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  // Configuration inputs
  input wire logic smi_to_serial_frame,
  input wire logic [EDGE_PINS-1:0] edge_pins,
  input wire logic [EDGE_PINS-1:0] edge_polarity,
  input wire logic [EDGE_PINS-1:0] edge_mode_select,
  input wire logic [EDGE_PINS-1:0] edge_group_enable,
  // Outputs watched
  input wire logic group_mgmt_irq_n_oe,
  input wire logic serial_frame_irq2,
  input wire logic smi_to_power_event,
  input wire logic [EDGE_PINS-1:0] either_edge_irq,
  input wire logic [EDGE_PINS-1:0] edge_gpio_data,
  input wire logic acpi_control_irq
);
  logic [7:0] en_a_q; // Shadow of first enable
  logic [7:0] en_b_q; // Shadow of second enable
  wire logic [EDGE_PINS-1:0] gate_w = edge_mode_select & edge_group_enable;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Shadows follow writes so readback needs no design state
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      en_a_q <= 8'h00;
    else if (req.wr && req.addr == 8'h14)
      en_a_q <= req.wdata;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      en_b_q <= 8'h00;
    else if (req.wr && req.addr == 8'h15)
      en_b_q <= req.wdata;
  // Read data lands one edge after the read strobe
  a_en_a_back: assert property
    (req.rd && req.addr == 8'h14 |=> rdata == en_a_q)
    else $error("first enable readback wrong");
  a_en_b_back: assert property
    (req.rd && req.addr == 8'h15 |=> rdata == en_b_q)
    else $error("second enable readback wrong");
  a_misc_reserved: assert property
    (req.rd && req.addr == 8'h16 |=> rdata[7:5] == 3'h0)
    else $error("reserved misc bits not zero");
  a_pin_floats: assert property
    (!en_b_q[7] && !$past(en_b_q[7]) |-> !group_mgmt_irq_n_oe)
    else $error("interrupt pin driven while disabled");
  a_pme_gated: assert property
    (!en_b_q[6] && !$past(en_b_q[6]) |-> !smi_to_power_event)
    else $error("power event fed while disabled");
  a_frame_select: assert property
    (serial_frame_irq2 |-> (smi_to_serial_frame ||
      $past(smi_to_serial_frame)) && (en_b_q[7] || $past(en_b_q[7])))
    else $error("serial frame slot driven wrongly");
  a_edge_gated: assert property
    ((either_edge_irq & ~(gate_w | $past(gate_w))) == '0)
    else $error("edge interrupt without mode and group");
  // Pin data passes three flops, so four quiet cycles settle it
  a_gpio_data: assert property
    ((($stable(edge_pins) && $stable(edge_polarity)) [*4]) |->
      edge_gpio_data == (edge_pins ^ edge_polarity))
    else $error("gpio data not pin xor polarity");
  a_sci_pulse: assert property
    (acpi_control_irq |=> !acpi_control_irq)
    else $error("control interrupt longer than a cycle");
  c_pin_on: cover property (group_mgmt_irq_n_oe);
  c_edge_irq: cover property (|either_edge_irq);
  c_sci: cover property (acpi_control_irq);
  c_frame: cover property (serial_frame_irq2);
endmodule
bind smi_group_and_edge_irq smi_group_asserts #(.EDGE_PINS(EDGE_PINS))
  chk_u (.*);
`default_nettype wire

// *** smi_host_model.sv ***
// Host side of the shared active-low management interrupt wire.
// Assumes a board pull-up holds the wire high when released.
`timescale 1ns/1ps
`default_nettype none
module smi_host_model
(
  // Pin driver from the block
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  // Resolved wire level
  output logic pin_level
);
  // Released wire shows the pull-up, never the last driven value
  assign pin_level = irq_n_oe ? irq_n_o : 1'h1;
endmodule
`default_nettype wire

// *** test_smi_group_and_edge_irq.sv ***
// Bench for the management interrupt group and either-edge block.
// Assumes the host model resolves the shared interrupt wire.
`timescale 1ns/1ps
`default_nettype none
module test_smi_group_and_edge_irq;
  logic clock = 1'h0, rstn = 1'h0, ir_mux_select = 1'h0;
  logic serial_b_receive = 1'h0, infrared_receive_alt = 1'h0;
  logic standby_supply_reset = 1'h0, smi_to_serial_frame = 1'h0;
  logic system_power_on_n = 1'h1;
  smi_group_pkg::reg_req_t req = '0;
  smi_group_pkg::smi_src_t src = '0;
  logic [3:0] edge_pins = '0, edge_mode_select = '0;
  logic [3:0] edge_polarity = '0, edge_group_enable = '0;
  logic [7:0] rdata;
  logic [3:0] either_edge_irq, edge_gpio_data;
  logic group_mgmt_irq_n_o, group_mgmt_irq_n_oe, serial_frame_irq2;
  logic smi_to_power_event, acpi_control_irq, pin_level;
  int errors = 0, samples_checked = 0, cycles = 0;
  smi_group_and_edge_irq #(.EDGE_PINS(4)) dut_u (.*);
  smi_host_model host_u (.irq_n_o(group_mgmt_irq_n_o),
    .irq_n_oe(group_mgmt_irq_n_oe), .pin_level(pin_level));
  always #10 clock = ~clock;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One register cycle; rdata is settled when it returns
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    req <= '{rd: r, wr: !r, addr: a, wdata: w};
    @(posedge clock);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    acc(1'h1, a, 8'h00);
    chk(n, rdata, e);
  endtask
  task automatic t_regs();
    rd(8'h13, 8'h00, "status");
    rd(8'h14, 8'h00, "en_a");
    rd(8'h15, 8'h00, "en_b");
    rd(8'h16, 8'h00, "misc");
    rd(8'h20, 8'h00, "unmapped");
    acc(1'h0, 8'h14, 8'hA5);
    rd(8'h14, 8'hA5, "en_a rw");
    acc(1'h0, 8'h14, 8'h00);
  endtask
  // Live bits follow sources; event bits clear on read
  task automatic t_status();
    @(posedge clock);
    src <= 14'h0034;
    settle(2);
    rd(8'h13, 8'h13, "live");
    @(posedge clock);
    src <= 14'h0008;
    @(posedge clock);
    src <= 14'h0001;
    settle(2);
    rd(8'h13, 8'h88, "events");
    rd(8'h13, 8'h00, "cleared");
    @(posedge clock);
    src <= '0;
  endtask
  task automatic ir(input logic sb, input logic alt, input logic mux);
    @(posedge clock);
    serial_b_receive <= sb;
    infrared_receive_alt <= alt;
    ir_mux_select <= mux;
    settle(4);
  endtask
  task automatic t_ir();
    ir(1'h1, 1'h0, 1'h0);
    rd(8'h13, 8'h04, "ir rise");
    ir(1'h0, 1'h0, 1'h0);
    rd(8'h13, 8'h04, "ir fall");
    ir(1'h0, 1'h0, 1'h1);
    rd(8'h13, 8'h00, "ir quiet");
    ir(1'h1, 1'h0, 1'h1);
    rd(8'h13, 8'h00, "ir unselected");
    ir(1'h1, 1'h1, 1'h1);
    rd(8'h13, 8'h04, "ir alt");
  endtask
  task automatic t_edge();
    @(posedge clock);
    edge_mode_select <= 4'hF;
    edge_group_enable <= 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      edge_pins[i] <= 1'h1;
      settle(4);
      rd(8'h16, 8'h01 << i, "edge set");
      chk("edge irq", {4'h0, either_edge_irq}, 8'h01 << i);
      acc(1'h0, 8'h16, 8'h00);
      rd(8'h16, 8'h01 << i, "edge keep");
      acc(1'h0, 8'h16, 8'h01 << i);
      rd(8'h16, 8'h00, "edge clear");
    end
    @(posedge clock);
    edge_mode_select <= 4'h5;
    edge_group_enable <= 4'hA;
    edge_pins <= 4'h0;
    settle(4);
    rd(8'h16, 8'h0F, "edge fall");
    chk("irq gated", {4'h0, either_edge_irq}, 8'h00);
    @(posedge clock);
    edge_polarity <= 4'h5;
    edge_pins <= 4'h3;
    settle(4);
    chk("gpio data", {4'h0, edge_gpio_data}, 8'h06);
    acc(1'h0, 8'h16, 8'h0F);
  endtask
  // One source on, its enable set, then excluded again
  task automatic route(input int s, input logic b, input int e);
    @(posedge clock);
    src <= 14'h0001 << s;
    acc(1'h0, 8'h14, b ? 8'h00 : 8'h01 << e);
    acc(1'h0, 8'h15, 8'h80 | (b ? 8'h01 << e : 8'h00));
    settle(3);
    chk("pin on", {7'h0, pin_level}, 8'h00);
    acc(1'h0, 8'h14, 8'h00);
    acc(1'h0, 8'h15, 8'h80);
    settle(3);
    chk("pin off", {7'h0, pin_level}, 8'h01);
  endtask
  task automatic t_route();
    for (int k = 0; k < 8; k++)
      route(13 - k, 1'h0, k);
    route(5, 1'h1, 0);
    route(4, 1'h1, 1);
    route(2, 1'h1, 4);
    route(1, 1'h1, 5);
    route(3, 1'h1, 3);
    ir(1'h1, 1'h0, 1'h1);
    route(13, 1'h1, 2);
    @(posedge clock);
    src <= 14'h0020;
    smi_to_serial_frame <= 1'h1;
    acc(1'h0, 8'h15, 8'hC1);
    settle(3);
    chk("frame", {6'h0, serial_frame_irq2, pin_level}, 8'h03);
    chk("pme on", {7'h0, smi_to_power_event}, 8'h01);
    acc(1'h0, 8'h15, 8'h01);
    settle(3);
    chk("all off", {5'h0, serial_frame_irq2, smi_to_power_event,
      group_mgmt_irq_n_oe}, 8'h00);
    acc(1'h0, 8'h15, 8'h00);
  endtask
  task automatic t_standby();
    int n;
    n = 0;
    @(posedge clock);
    standby_supply_reset <= 1'h1;
    settle(4);
    rd(8'h16, 8'h10, "standby");
    @(posedge clock);
    system_power_on_n <= 1'h0;
    repeat (10)
    begin
      settle(1);
      if (acpi_control_irq === 1'h1)
        n++;
    end
    chk("sci", n[7:0], 8'h01);
    acc(1'h0, 8'h16, 8'h10);
    rd(8'h16, 8'h00, "standby clear");
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'h1;
    t_regs();
    t_status();
    t_ir();
    t_edge();
    t_route();
    t_standby();
    wrap_up();
  end
endmodule
`default_nettype wire
